// ==== swu_pkg.sv ====
/*
 * Shared constants, state types and the CRC step for the single-wire UART link.
 * Assumes a 100 MHz core clock on both ends.
 */
package swu_pkg;
  // ==========================================================
  // Clock and baud limits
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MIN_BAUD = 9000;
  localparam int MAX_BIT_CYCLES = CLK_HZ / MIN_BAUD;
  localparam int CNT_W = 24;
  localparam logic [CNT_W-1:0] GLITCH_CYCLES = 24'h000010;
  localparam logic [CNT_W-1:0] SYNC_MAX_CYCLES = CNT_W'(4 * MAX_BIT_CYCLES);
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
  // ==========================================================
  // Datagram layout
  localparam logic [7:0] SYNC_BYTE = 8'h05;
  localparam int WR_FLAG_BIT = 7;
  localparam logic [2:0] WR_LAST = 3'h6;
  localparam logic [2:0] RD_LAST = 3'h2;
  localparam logic [2:0] REPLY_LAST = 3'h6;
  localparam logic [2:0] DATA_LAST = 3'h5;
  localparam logic [3:0] FRAME_LAST = 4'h9;
  localparam logic [3:0] SYNC_RESUME_IDX = 4'h4;
  // ==========================================================
  // Timing in bit times
  localparam logic [CNT_W-1:0] TIMEOUT_BITS = 24'h00003f;
  localparam logic [CNT_W-1:0] RECOVER_BITS = 24'h00000c;
  localparam logic [7:0] HOLD_BITS = 8'h04;
  localparam logic [7:0] HOST_GAP_BITS = 8'h0c;
  localparam logic [7:0] REPLY_WAIT_BITS = 8'ha0;
  // ==========================================================
  // States
  typedef enum logic [6:0] {
    D_IDLE = 7'h01, D_SYNC = 7'h02, D_RX = 7'h04, D_GAP = 7'h08,
    D_REC = 7'h10, D_DELAY = 7'h20, D_TX = 7'h40
  } swu_dev_state_e;
  typedef enum logic [5:0] {
    H_IDLE = 6'h01, H_TX = 6'h02, H_WAIT = 6'h04, H_RX = 6'h08,
    H_GAP = 6'h10, H_HOLD = 6'h20
  } swu_host_state_e;

  // Bitwise CRC step, LSB of the byte first, start value zero
  function automatic logic [7:0] swu_crc8(input logic [7:0] crc_in, input logic [7:0] byte_in);
    logic [7:0] c;
    c = crc_in;
    for (int i = 0; i < 8; i++) begin
      c = {c[6:0], c[7] ^ c[1] ^ c[0] ^ byte_in[i]};
    end
    return c;
  endfunction
endpackage

// ==== swu_link_if.sv ====
/*
 * Shared single-wire link between device and host ends.
 * Resolves both wires from the enables; an undriven line idles high (true) / low (inverted).
 */
interface swu_link_if;
  logic dev_true_o;
  logic dev_true_oe;
  logic dev_inv_o;
  logic dev_inv_oe;
  logic host_o;
  logic host_oe;
  logic serial_line_true;
  logic serial_line_inverted;

  assign serial_line_true = dev_true_oe ? dev_true_o : (host_oe ? host_o : 1'b1);
  assign serial_line_inverted = dev_inv_oe ? dev_inv_o : (host_oe ? ~host_o : 1'b0);

  modport device(input serial_line_true, input serial_line_inverted,
                 output dev_true_o, output dev_true_oe, output dev_inv_o, output dev_inv_oe);
  modport host(input serial_line_true, output host_o, output host_oe);
endinterface

// ==== swu_device.sv ====
/*
 * Device end of the single-wire UART: baud detection, datagram receive, write strobe,
 * datagram counter and read reply. Expects a host that keeps its side of the protocol.
 */
// Notes on behaviour
// - every datagram opens with sync nibble byte
// - write is sync, address, four data, CRC
// - start/stop framing, LSB first, MSB byte first
// - bit time from start to sync fall
// - host baud between 9000 and clock/16
// - over 63 bit times between starts resets
// - after reset wait 12 idle bit times
// - short pulse under 16 cycles is glitch
// - CRC and other errors use same recovery
// - host never drops baud below 15 percent
// - accepted writes bump 8-bit wrapping counter
// - read request is sync, address, CRC
// - reply uses the measured baud rate
// - reply waits eight-bit-time steps, default eight
// - reply is sync, address, data, CRC
// - release drivers four bit times after reply
// - CRC x^8+x^2+x+1, zero start, LSB first
// - only correct-CRC datagrams acted upon
// - reply data shifted live, no snapshot
// - drivers enabled only during reply
// - inverted line is complement of true
// - address MSB set means write
module swu_device (
  input wire logic core_clk_in, // 100 MHz clock
  input wire logic nrst_in, // async reset, active low
  swu_link_if.device link, // shared line
  input wire logic [3:0] reply_delay_setting_in, // reply delay in steps of 8 bits
  input wire logic [31:0] rd_data_in, // live read data for rd_addr_out
  output logic [6:0] rd_addr_out, // register being read or written
  output logic [31:0] wr_data_out, // write data
  output logic wr_strobe_out, // one-cycle write pulse
  output logic [7:0] datagram_count_out // accepted write counter
);
  localparam int W = swu_pkg::CNT_W;
  // ==========================================================
  // State
  swu_pkg::swu_dev_state_e state, next_state;
  logic [W-1:0] tmr, next_tmr, cnt, next_cnt, gap, next_gap;
  logic [W-1:0] bit_time, next_bit_time, good_bit, next_good_bit;
  logic good_valid, next_good_valid;
  logic [3:0] bit_idx, next_bit_idx;
  logic [2:0] byte_idx, next_byte_idx;
  logic [7:0] data, next_data, crc, next_crc, count, next_count, bits, next_bits;
  logic is_write, next_is_write, falls, next_falls, wr, next_wr, rx_prev;
  logic [6:0] addr, next_addr;
  logic [31:0] wdata, next_wdata;
  logic [9:0] txsh, next_txsh;
  logic rx, fall, tick;
  logic [W-1:0] meas, base;
  logic [2:0] nb;
  logic [7:0] tx_byte;
  logic [3:0] delay_steps;

  assign rx = link.serial_line_true;
  assign fall = rx_prev & ~rx;
  assign tick = (tmr == '0);
  assign meas = cnt + swu_pkg::CNT_ONE;
  // Gap timeout and recovery wait use the last good datagram's bit time once one exists
  assign base = good_valid ? good_bit : bit_time;
  assign nb = byte_idx + 3'h1;
  assign delay_steps = (reply_delay_setting_in == 4'h0) ? 4'h1 : reply_delay_setting_in;

  // ==========================================================
  // Reply byte source
  always_comb begin
    if (nb == 3'h1) begin
      tx_byte = {1'b0, addr};
    end else if (nb == swu_pkg::REPLY_LAST) begin
      tx_byte = crc;
    end else begin
      tx_byte = 8'(rd_data_in >> {(swu_pkg::DATA_LAST - nb), 3'b000});
    end
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_state = state;
    next_tmr = tick ? tmr : tmr - swu_pkg::CNT_ONE;
    next_cnt = cnt;
    next_gap = gap + swu_pkg::CNT_ONE;
    next_bit_time = bit_time;
    next_good_bit = good_bit;
    next_good_valid = good_valid;
    next_bit_idx = bit_idx;
    next_byte_idx = byte_idx;
    next_data = data;
    next_crc = crc;
    next_count = count;
    next_bits = bits;
    next_is_write = is_write;
    next_falls = falls;
    next_wr = 1'b0;
    next_addr = addr;
    next_wdata = wdata;
    next_txsh = txsh;
    case (state)
      swu_pkg::D_IDLE: begin
        // hunt for a new start bit
        if (!rx) begin
          next_state = swu_pkg::D_SYNC;
          next_cnt = '0;
          next_gap = '0;
          next_falls = 1'b0;
          next_crc = '0;
          next_byte_idx = '0;
        end
      end
      swu_pkg::D_SYNC: begin
        next_cnt = meas;
        // short low pulse is a glitch
        if (!falls && rx && meas < swu_pkg::GLITCH_CYCLES) begin
          next_state = swu_pkg::D_REC;
          next_cnt = '0;
        end else if (fall) begin
          if (!falls) begin
            next_falls = 1'b1;
          end else begin
            next_bit_time = meas >> 2;
            next_tmr = meas >> 3;
            next_bit_idx = swu_pkg::SYNC_RESUME_IDX;
            next_data = swu_pkg::SYNC_BYTE;
            next_state = swu_pkg::D_RX;
          end
        end else if (cnt >= swu_pkg::SYNC_MAX_CYCLES) begin
          next_state = swu_pkg::D_REC;
          next_cnt = '0;
        end
      end
      swu_pkg::D_RX: begin
        if (tick) begin
          next_tmr = bit_time - swu_pkg::CNT_ONE;
          next_bit_idx = bit_idx + 4'h1;
          if ((bit_idx == 4'h0 && rx) || (bit_idx == swu_pkg::FRAME_LAST && !rx)) begin
            next_state = swu_pkg::D_REC;
            next_cnt = '0;
          end else if (bit_idx == swu_pkg::FRAME_LAST) begin
            if (byte_idx == 3'h0 && data != swu_pkg::SYNC_BYTE) begin
              next_state = swu_pkg::D_REC;
              next_cnt = '0;
            end else if (byte_idx == (is_write ? swu_pkg::WR_LAST : swu_pkg::RD_LAST)) begin
              if (crc == data) begin
                next_good_bit = bit_time;
                next_good_valid = 1'b1;
                if (is_write) begin
                  next_wr = 1'b1;
                  next_count = count + 8'h01;
                  next_state = swu_pkg::D_IDLE;
                end else begin
                  next_bits = {1'b0, delay_steps, 3'b000};
                  next_state = swu_pkg::D_DELAY;
                end
              end else begin
                next_state = swu_pkg::D_REC;
                next_cnt = '0;
              end
            end else begin
              next_crc = swu_pkg::swu_crc8(crc, data);
              next_byte_idx = nb;
              next_state = swu_pkg::D_GAP;
              if (byte_idx == 3'h1) begin
                next_is_write = data[swu_pkg::WR_FLAG_BIT];
                next_addr = data[6:0];
              end else if (byte_idx != 3'h0) begin
                next_wdata = {wdata[23:0], data};
              end
            end
          end else if (bit_idx != 4'h0) begin
            next_data[3'(bit_idx - 4'h1)] = rx;
          end
        end
      end
      swu_pkg::D_GAP: begin
        if (!rx) begin
          next_state = swu_pkg::D_RX;
          next_bit_idx = '0;
          next_tmr = bit_time >> 1;
          next_gap = '0;
        end else if (gap > W'(swu_pkg::TIMEOUT_BITS * base)) begin
          next_state = swu_pkg::D_REC;
          next_cnt = '0;
        end
      end
      swu_pkg::D_REC: begin
        next_cnt = rx ? meas : '0;
        if (cnt >= W'(swu_pkg::RECOVER_BITS * base)) begin
          next_state = swu_pkg::D_IDLE;
        end
      end
      swu_pkg::D_DELAY: begin
        if (tick) begin
          next_tmr = bit_time - swu_pkg::CNT_ONE;
          next_bits = bits - 8'h01;
          if (bits == 8'h01) begin
            next_state = swu_pkg::D_TX;
            next_byte_idx = '0;
            next_bit_idx = '0;
            next_txsh = {1'b1, swu_pkg::SYNC_BYTE, 1'b0};
            next_crc = swu_pkg::swu_crc8(8'h00, swu_pkg::SYNC_BYTE);
          end
        end
      end
      swu_pkg::D_TX: begin
        if (tick) begin
          next_tmr = bit_time - swu_pkg::CNT_ONE;
          if (bit_idx == swu_pkg::FRAME_LAST + 4'h1) begin
            next_bits = bits - 8'h01;
            if (bits == 8'h01) begin
              next_state = swu_pkg::D_IDLE;
            end
          end else if (bit_idx == swu_pkg::FRAME_LAST) begin
            if (byte_idx == swu_pkg::REPLY_LAST) begin
              next_bit_idx = bit_idx + 4'h1;
              next_bits = swu_pkg::HOLD_BITS;
            end else begin
              next_byte_idx = nb;
              next_bit_idx = '0;
              next_txsh = {1'b1, tx_byte, 1'b0};
              next_crc = swu_pkg::swu_crc8(crc, tx_byte);
            end
          end else begin
            next_txsh = {1'b1, txsh[9:1]};
            next_bit_idx = bit_idx + 4'h1;
          end
        end
      end
      default: next_state = swu_pkg::D_IDLE;
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= swu_pkg::D_IDLE;
      tmr <= '0;
      cnt <= '0;
      gap <= '0;
      bit_time <= swu_pkg::GLITCH_CYCLES;
      good_bit <= swu_pkg::GLITCH_CYCLES;
      good_valid <= 1'b0;
      bit_idx <= '0;
      byte_idx <= '0;
      data <= '0;
      crc <= '0;
      count <= '0;
      bits <= '0;
      is_write <= 1'b0;
      falls <= 1'b0;
      wr <= 1'b0;
      addr <= '0;
      wdata <= '0;
      txsh <= '1;
      rx_prev <= 1'b1;
    end else begin
      state <= next_state;
      tmr <= next_tmr;
      cnt <= next_cnt;
      gap <= next_gap;
      bit_time <= next_bit_time;
      good_bit <= next_good_bit;
      good_valid <= next_good_valid;
      bit_idx <= next_bit_idx;
      byte_idx <= next_byte_idx;
      data <= next_data;
      crc <= next_crc;
      count <= next_count;
      bits <= next_bits;
      is_write <= next_is_write;
      falls <= next_falls;
      wr <= next_wr;
      addr <= next_addr;
      wdata <= next_wdata;
      txsh <= next_txsh;
      rx_prev <= rx;
    end
  end

  // ==========================================================
  // Outputs
  // drive only while replying
  assign link.dev_true_oe = (state == swu_pkg::D_TX);
  assign link.dev_inv_oe = (state == swu_pkg::D_TX);
  assign link.dev_true_o = txsh[0];
  assign link.dev_inv_o = ~txsh[0];
  assign rd_addr_out = addr;
  assign wr_data_out = wdata;
  assign wr_strobe_out = wr;
  assign datagram_count_out = count;
endmodule

// ==== swu_host.sv ====
/*
 * Host end of the single-wire UART: sends write and read-request datagrams at a
 * chosen bit time and collects read replies. Expects the device end on the link.
 */
module swu_host (
  input wire logic core_clk_in, // 100 MHz clock
  input wire logic nrst_in, // async reset, active low
  swu_link_if.host link, // shared line
  input wire logic [15:0] bit_cycles_in, // bit time in clocks, 16..11111
  input wire logic req_valid_in, // request present
  input wire logic req_write_in, // 1 write, 0 read
  input wire logic [6:0] req_addr_in, // register address
  input wire logic [31:0] req_wdata_in, // write data
  output logic req_ready_out, // request taken when high with valid
  output logic rsp_valid_out, // one-cycle read result pulse
  output logic rsp_ok_out, // reply framing, sync, address and CRC good
  output logic [31:0] rsp_data_out // read data
);
  swu_pkg::swu_host_state_e state, next_state;
  logic [15:0] tmr, next_tmr;
  logic [3:0] bit_idx, next_bit_idx;
  logic [2:0] byte_idx, next_byte_idx, last, next_last;
  logic [7:0] data, next_data, crc, next_crc, bits, next_bits, tx_byte;
  logic [9:0] txsh, next_txsh;
  logic [31:0] word, next_word, rdata, next_rdata;
  logic [6:0] addr, next_addr;
  logic is_write, next_is_write, ok, next_ok, rv, next_rv, rx, tick;
  logic [2:0] nb;

  assign rx = link.serial_line_true;
  assign tick = (tmr == 16'h0000);
  assign nb = byte_idx + 3'h1;

  // ==========================================================
  // Outgoing byte source
  always_comb begin
    if (nb == 3'h1) begin
      tx_byte = {is_write, addr};
    end else if (nb == last) begin
      tx_byte = crc;
    end else begin
      tx_byte = word[31:24];
    end
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_state = state;
    next_tmr = tick ? bit_cycles_in - 16'h0001 : tmr - 16'h0001;
    next_bit_idx = bit_idx;
    next_byte_idx = byte_idx;
    next_last = last;
    next_data = data;
    next_crc = crc;
    next_bits = bits;
    next_txsh = txsh;
    next_word = word;
    next_rdata = rdata;
    next_addr = addr;
    next_is_write = is_write;
    next_ok = ok;
    next_rv = 1'b0;
    case (state)
      swu_pkg::H_IDLE: begin
        if (req_valid_in) begin
          next_state = swu_pkg::H_TX;
          next_is_write = req_write_in;
          next_addr = req_addr_in;
          next_word = req_wdata_in;
          next_last = req_write_in ? swu_pkg::WR_LAST : swu_pkg::RD_LAST;
          next_byte_idx = '0;
          next_bit_idx = '0;
          next_tmr = bit_cycles_in - 16'h0001;
          next_txsh = {1'b1, swu_pkg::SYNC_BYTE, 1'b0};
          next_crc = swu_pkg::swu_crc8(8'h00, swu_pkg::SYNC_BYTE);
        end
      end
      swu_pkg::H_TX: begin
        if (tick) begin
          if (bit_idx != swu_pkg::FRAME_LAST) begin
            next_txsh = {1'b1, txsh[9:1]};
            next_bit_idx = bit_idx + 4'h1;
          end else if (byte_idx == last) begin
            next_byte_idx = '0;
            next_crc = '0;
            next_ok = 1'b1;
            next_state = is_write ? swu_pkg::H_GAP : swu_pkg::H_WAIT;
            next_bits = is_write ? swu_pkg::HOST_GAP_BITS : swu_pkg::REPLY_WAIT_BITS;
          end else begin
            next_byte_idx = nb;
            next_bit_idx = '0;
            next_txsh = {1'b1, tx_byte, 1'b0};
            next_crc = swu_pkg::swu_crc8(crc, tx_byte);
            if (nb != 3'h1) begin
              next_word = {word[23:0], 8'h00};
            end
          end
        end
      end
      swu_pkg::H_WAIT: begin
        if (!rx) begin
          next_state = swu_pkg::H_RX;
          next_bit_idx = '0;
          next_tmr = bit_cycles_in >> 1;
        end else if (tick) begin
          next_bits = bits - 8'h01;
          if (bits == 8'h01) begin
            next_rv = 1'b1;
            next_ok = 1'b0;
            next_state = swu_pkg::H_GAP;
            next_bits = swu_pkg::HOST_GAP_BITS;
          end
        end
      end
      swu_pkg::H_RX: begin
        if (tick) begin
          next_bit_idx = bit_idx + 4'h1;
          if ((bit_idx == 4'h0 && rx) || (bit_idx == swu_pkg::FRAME_LAST && !rx)) begin
            next_ok = 1'b0;
          end
          if (bit_idx == swu_pkg::FRAME_LAST) begin
            next_crc = swu_pkg::swu_crc8(crc, data);
            next_byte_idx = nb;
            next_state = swu_pkg::H_WAIT;
            next_bits = swu_pkg::REPLY_WAIT_BITS;
            if ((byte_idx == 3'h0 && data != swu_pkg::SYNC_BYTE)
                || (byte_idx == 3'h1 && data != {1'b0, addr})) begin
              next_ok = 1'b0;
            end
            if (byte_idx == swu_pkg::REPLY_LAST) begin
              next_rv = 1'b1;
              next_ok = ok && (crc == data) && rx;
              next_state = swu_pkg::H_GAP;
              next_bits = swu_pkg::HOST_GAP_BITS;
            end else if (byte_idx > 3'h1) begin
              next_rdata = {rdata[23:0], data};
            end
          end else if (bit_idx != 4'h0) begin
            next_data[3'(bit_idx - 4'h1)] = rx;
          end
        end
      end
      swu_pkg::H_GAP: begin
        // twelve idle bit times
        // Idle spacing lets the device finish any recovery
        if (tick) begin
          next_bits = bits - 8'h01;
          if (bits == 8'h01) begin
            next_state = swu_pkg::H_IDLE;
          end
        end
      end
      default: next_state = swu_pkg::H_IDLE;
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= swu_pkg::H_IDLE;
      tmr <= '0;
      bit_idx <= '0;
      byte_idx <= '0;
      last <= '0;
      data <= '0;
      crc <= '0;
      bits <= '0;
      txsh <= '1;
      word <= '0;
      rdata <= '0;
      addr <= '0;
      is_write <= 1'b0;
      ok <= 1'b0;
      rv <= 1'b0;
    end else begin
      state <= next_state;
      tmr <= next_tmr;
      bit_idx <= next_bit_idx;
      byte_idx <= next_byte_idx;
      last <= next_last;
      data <= next_data;
      crc <= next_crc;
      bits <= next_bits;
      txsh <= next_txsh;
      word <= next_word;
      rdata <= next_rdata;
      addr <= next_addr;
      is_write <= next_is_write;
      ok <= next_ok;
      rv <= next_rv;
    end
  end

  assign link.host_oe = (state == swu_pkg::H_TX);
  assign link.host_o = txsh[0];
  assign req_ready_out = (state == swu_pkg::H_IDLE);
  assign rsp_valid_out = rv;
  assign rsp_ok_out = ok;
  assign rsp_data_out = rdata;
endmodule

// ==== swu_link_props.sv ====
/* Checker for the shared single-wire link.
   Assumes one clock domain and the interface signals wired in by name. */
module swu_link_props (
  input wire logic core_clk_in, // clock
  input wire logic nrst_in, // reset, active low
  input wire logic dev_true_o, // device true drive
  input wire logic dev_true_oe, // device true enable
  input wire logic dev_inv_o, // device inverted drive
  input wire logic dev_inv_oe, // device inverted enable
  input wire logic host_o, // host drive
  input wire logic host_oe // host enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  // ==========================================
  // Device drive
  a_inv_compl: assert property (dev_true_oe |-> dev_inv_o == ~dev_true_o)
    else $error("inverted drive not complement");
  a_oe_paired: assert property (dev_true_oe == dev_inv_oe)
    else $error("enables differ");
  a_no_clash: assert property (!(dev_true_oe && host_oe))
    else $error("both ends drive");
  a_reply_start: assert property ($rose(dev_true_oe) |-> ##[0:1] !dev_true_o [*8])
    else $error("reply start bit short");
  // Four trailing high bits are at least 64 cycles
  a_reply_tail: assert property ($fell(dev_true_oe) |-> $past(dev_true_o) && $past(dev_true_o, 60))
    else $error("release not after high tail");
  a_dev_bit: assert property (dev_true_oe && $rose(dev_true_o) |-> dev_true_o [*8])
    else $error("device bit too short");
  // ==========================================
  // Host drive
  a_host_start: assert property ($rose(host_oe) |-> !host_o [*8])
    else $error("host start bit short");
  a_host_stop: assert property ($fell(host_oe) |-> $past(host_o) && $past(host_o, 8))
    else $error("host release without stop");
  a_host_bit: assert property (host_oe && $fell(host_o) |-> !host_o [*8])
    else $error("host bit too short");
  c_reply: cover property ($rose(dev_true_oe));
  c_host_end: cover property ($fell(host_oe));
  c_reply_end: cover property ($fell(dev_true_oe));
endmodule

// ==== tb.sv ====
/* Self-checking bench: host and device ends joined on one link, plus a
   second device driven directly to inject faults. Assumes 100 MHz clock. */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in, nrst_in, req_valid_in, req_write_in, req_ready_out, rsp_valid_out;
  logic rsp_ok_out, wr_strobe_out;
  logic [3:0] dly;
  logic [15:0] bc;
  logic [6:0] addr, rd_addr_out;
  logic [31:0] wdata, rd_data, rsp_data_out, wr_data_out;
  logic [7:0] count, count2, c0, f [7];
  int n_fail, samples_checked, n, d;
  swu_link_if lk();
  swu_link_if lk2();
  swu_device swu_device_i(.core_clk_in(core_clk_in), .nrst_in(nrst_in), .link(lk),
    .reply_delay_setting_in(dly), .rd_data_in(rd_data), .rd_addr_out(rd_addr_out),
    .wr_data_out(wr_data_out), .wr_strobe_out(wr_strobe_out), .datagram_count_out(count));
  swu_device swu_device_i2(.core_clk_in(core_clk_in), .nrst_in(nrst_in), .link(lk2),
    .reply_delay_setting_in(4'h0), .rd_data_in(32'h0), .rd_addr_out(), .wr_data_out(),
    .wr_strobe_out(), .datagram_count_out(count2));
  swu_host swu_host_i(.core_clk_in(core_clk_in), .nrst_in(nrst_in), .link(lk),
    .bit_cycles_in(bc), .req_valid_in(req_valid_in), .req_write_in(req_write_in),
    .req_addr_in(addr), .req_wdata_in(wdata), .req_ready_out(req_ready_out),
    .rsp_valid_out(rsp_valid_out), .rsp_ok_out(rsp_ok_out), .rsp_data_out(rsp_data_out));
  swu_link_props swu_link_props_i(.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .dev_true_o(lk.dev_true_o), .dev_true_oe(lk.dev_true_oe), .dev_inv_o(lk.dev_inv_o),
    .dev_inv_oe(lk.dev_inv_oe), .host_o(lk.host_o), .host_oe(lk.host_oe));
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  // ==========================================
  // Helpers
  function automatic logic [7:0] crc_of(input int len);
    logic [7:0] c = 8'h00;
    for (int k = 0; k < len; k++)
      for (int i = 0; i < 8; i++) c = {c[6:0], c[7] ^ c[1] ^ c[0] ^ f[k][i]};
    return c;
  endfunction
  function automatic logic sig(input int w);
    case (w)
      0: return lk.host_oe;
      1: return lk.dev_true_oe;
      2: return lk.dev_true_o;
      3: return rsp_valid_out;
      4: return wr_strobe_out;
      default: return req_ready_out;
    endcase
  endfunction
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    samples_checked++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  // Bounded wait, sampled at falling edges
  task automatic wait_on(input int w, input logic lvl);
    n = 0;
    while (sig(w) !== lvl) begin
      @(negedge core_clk_in);
      n++;
      if (n > 30000) begin
        n_fail++;
        $display("Error wait %0d expected %b seen timeout", w, lvl);
        summarize();
      end
    end
  endtask
  task automatic request(input logic w);
    wait_on(5, 1'b1);
    c0 = count;
    req_valid_in = 1'b1;
    req_write_in = w;
    @(negedge core_clk_in);
    req_valid_in = 1'b0;
  endtask
  task automatic build(input logic [6:0] a, input logic [31:0] v);
    f[0] = 8'h05;
    f[1] = {1'b1, a};
    {f[2], f[3], f[4], f[5]} = v;
    f[6] = crc_of(6);
  endtask
  task automatic d2_bit(input logic v, input int cyc);
    lk2.host_o = v;
    repeat (cyc) @(negedge core_clk_in);
  endtask
  // Bytes framed at 16 clocks a bit, optional pause after the address byte
  task automatic d2_dg(input int pause);
    lk2.host_oe = 1'b1;
    for (int k = 0; k < 7; k++) begin
      d2_bit(1'b0, 16);
      for (int i = 0; i < 8; i++) d2_bit(f[k][i], 16);
      d2_bit(1'b1, 16);
      if (k == 1) d2_bit(1'b1, pause);
    end
    lk2.host_oe = 1'b0;
    repeat (320) @(negedge core_clk_in);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    nrst_in = 1'b0;
    {req_valid_in, req_write_in, addr, wdata, rd_data, dly} = '0;
    bc = 16'h0010;
    lk2.host_o = 1'b1;
    lk2.host_oe = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    void'($urandom(28951));
    repeat (8) @(negedge core_clk_in);
    nrst_in = 1'b1;
    for (int t = 0; t < 8; t++) begin
      // 16 to 48 clocks a bit
      bc = (t < 2) ? 16'h0010 : 16'(16 + $urandom_range(32));
      addr = (t == 0) ? 7'h7f : 7'($urandom);
      wdata = (t == 1) ? 32'hffffffff : $urandom;
      request(1'b1);
      wait_on(4, 1'b1);
      chk("write addr", {25'h0, addr}, {25'h0, rd_addr_out});
      chk("write data", wdata, wr_data_out);
      wait_on(5, 1'b1);
      chk("count write", {24'h0, c0 + 8'h01}, {24'h0, count});
      dly = (t == 2) ? 4'h0 : (t == 3) ? 4'hf : 4'($urandom_range(3));
      rd_data = $urandom;
      request(1'b0);
      wait_on(0, 1'b1);
      wait_on(0, 1'b0);
      wait_on(1, 1'b1);
      d = 8 * ((dly == 4'h0) ? 1 : int'(dly)) * int'(bc);
      chk_rng("reply delay", d - int'(bc), d + 4, n);
      wait_on(2, 1'b0);
      wait_on(2, 1'b1);
      chk_rng("reply bit", int'(bc) - 1, int'(bc) + 1, n);
      wait_on(3, 1'b1);
      chk("reply ok", 32'h1, {31'h0, rsp_ok_out});
      chk("reply data", rd_data, rsp_data_out);
      wait_on(5, 1'b1);
      chk("count read", {24'h0, c0}, {24'h0, count});
    end
    // Fault injection on the second device
    build(7'h10, $urandom);
    f[6] = f[6] ^ 8'h01;
    d2_dg(0);
    chk("count bad crc", 32'h0, {24'h0, count2});
    build(7'h11, $urandom);
    lk2.host_oe = 1'b1;
    d2_bit(1'b0, 8);
    d2_bit(1'b1, 32);
    d2_dg(0);
    chk("count glitch", 32'h0, {24'h0, count2});
    d2_dg(1120);
    chk("count pause", 32'h0, {24'h0, count2});
    d2_dg(0);
    chk("count good", 32'h1, {24'h0, count2});
    summarize();
  end
endmodule
